// file: src/dsoc_ctrl.sv
`timescale 1ns/10ps
module dsoc_ctrl (
   input wire logic clk,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic [12:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic sync_pin,
   input wire logic output_enable_pin_active_low,
   input wire logic rate_ref_pin,
   output logic div_sync_pulse,
   output logic data_output_enable,
   output logic low_rate_backup_oscillator,
   output logic low_rate_flag,
   output logic sdio_pulldown_en
);
   // all flop state in one struct: registers, synchronisers, registered outputs
   typedef struct packed
   {
      dsoc_pkg::dsoc_sync_ctrl_t sync_ctrl;
      dsoc_pkg::dsoc_pin_opts_t opts;
      logic [2:0] sync_sh;
      logic [1:0] oe_sh;
      logic [7:0] rdata;
      logic pulse;
      logic data_oe;
      logic osc;
      logic pd_en;
   } dsoc_ctrl_state_t;

   dsoc_ctrl_state_t s_reg;
   dsoc_ctrl_state_t s_next;
   // decoded strobes and the detector's verdict
   logic low_rate;
   logic sync_edge;
   logic fire;
   logic wr_sync;
   logic wr_opts;

   ////////////////////////////////////////////////////////////////////////////
   // low encode rate monitor
   dsoc_rate_detect #(
      .MIN_EDGES(dsoc_pkg::MIN_EDGES_PER_REF),
      .CNT_W(8)
   ) u_rate_detect (
      .clk(clk),
      .rstn(rstn),
      .enable(s_reg.opts.det_en),
      .ref_pin(rate_ref_pin),
      .low_rate(low_rate)
   );

   ////////////////////////////////////////////////////////////////////////////
   // sync edge and register write decode
   assign sync_edge = s_reg.sync_sh[1] && !s_reg.sync_sh[2];
   assign fire = sync_edge && s_reg.sync_ctrl.master && s_reg.sync_ctrl.div_en;
   // writes decode the full address; unmapped writes fall through untouched
   assign wr_sync = reg_wr && (reg_addr == dsoc_pkg::SYNC_CTRL_ADDR);
   assign wr_opts = reg_wr && (reg_addr == dsoc_pkg::PIN_OPTS_ADDR);

   // next state; a host write lands after the auto-clear so a fresh arm is kept
   always_comb
   begin
      s_next = s_reg;
      s_next.sync_sh = {s_reg.sync_sh[1:0], sync_pin};
      s_next.oe_sh = {s_reg.oe_sh[0], output_enable_pin_active_low};
      // realign strobe is the registered fire, one clock wide
      s_next.pulse = fire;
      // one-shot mode drops its own enable as the realign goes out
      if (fire && s_reg.sync_ctrl.next_only)
      begin
         s_next.sync_ctrl.div_en = 1'b0;
      end
      if (wr_sync)
      begin
         s_next.sync_ctrl.master = reg_wdata[dsoc_pkg::SYNC_MASTER_BIT];
         s_next.sync_ctrl.div_en = reg_wdata[dsoc_pkg::SYNC_DIV_EN_BIT];
         s_next.sync_ctrl.next_only = reg_wdata[dsoc_pkg::SYNC_NEXT_ONLY_BIT];
      end
      if (wr_opts)
      begin
         s_next.opts.oe_pin_en = reg_wdata[dsoc_pkg::OPT_OE_PIN_EN_BIT];
         s_next.opts.det_en = reg_wdata[dsoc_pkg::OPT_DET_EN_BIT];
         s_next.opts.run_osc = reg_wdata[dsoc_pkg::OPT_RUN_OSC_BIT];
         s_next.opts.pd_dis = reg_wdata[dsoc_pkg::OPT_PD_DIS_BIT];
      end
      // readback, reserved bits and unmapped addresses read zero
      s_next.rdata = 8'h00;
      if (reg_addr == dsoc_pkg::SYNC_CTRL_ADDR)
      begin
         s_next.rdata[dsoc_pkg::SYNC_MASTER_BIT] = s_reg.sync_ctrl.master;
         s_next.rdata[dsoc_pkg::SYNC_DIV_EN_BIT] = s_reg.sync_ctrl.div_en;
         s_next.rdata[dsoc_pkg::SYNC_NEXT_ONLY_BIT] = s_reg.sync_ctrl.next_only;
      end
      else if (reg_addr == dsoc_pkg::PIN_OPTS_ADDR)
      begin
         s_next.rdata[dsoc_pkg::OPT_OE_PIN_EN_BIT] = s_reg.opts.oe_pin_en;
         s_next.rdata[dsoc_pkg::OPT_DET_EN_BIT] = s_reg.opts.det_en;
         s_next.rdata[dsoc_pkg::OPT_RUN_OSC_BIT] = s_reg.opts.run_osc;
         s_next.rdata[dsoc_pkg::OPT_PD_DIS_BIT] = s_reg.opts.pd_dis;
      end
      // pin gating; with the pin disabled the outputs simply stay on
      s_next.data_oe = !s_reg.opts.oe_pin_en || !s_reg.oe_sh[1];
      // the forced run bit wins over whatever the detector says
      s_next.osc = s_reg.opts.run_osc || (s_reg.opts.det_en && low_rate);
      s_next.pd_en = !s_reg.opts.pd_dis;
   end

   // state register with documented reset values
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         // synchronisers and strobes clear; register bits come from the reset words
         s_reg <= '0;
         s_reg.sync_ctrl.master <= dsoc_pkg::SYNC_CTRL_RESET[dsoc_pkg::SYNC_MASTER_BIT];
         s_reg.sync_ctrl.div_en <= dsoc_pkg::SYNC_CTRL_RESET[dsoc_pkg::SYNC_DIV_EN_BIT];
         s_reg.sync_ctrl.next_only <= dsoc_pkg::SYNC_CTRL_RESET[dsoc_pkg::SYNC_NEXT_ONLY_BIT];
         s_reg.opts.oe_pin_en <= dsoc_pkg::PIN_OPTS_RESET[dsoc_pkg::OPT_OE_PIN_EN_BIT];
         s_reg.opts.det_en <= dsoc_pkg::PIN_OPTS_RESET[dsoc_pkg::OPT_DET_EN_BIT];
         s_reg.opts.run_osc <= dsoc_pkg::PIN_OPTS_RESET[dsoc_pkg::OPT_RUN_OSC_BIT];
         s_reg.opts.pd_dis <= dsoc_pkg::PIN_OPTS_RESET[dsoc_pkg::OPT_PD_DIS_BIT];
         s_reg.data_oe <= 1'b1;
         s_reg.pd_en <= 1'b1;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // outputs, all straight from flops
   assign reg_rdata = s_reg.rdata;
   assign div_sync_pulse = s_reg.pulse;
   assign data_output_enable = s_reg.data_oe;
   assign low_rate_backup_oscillator = s_reg.osc;
   assign low_rate_flag = low_rate;
   assign sdio_pulldown_en = s_reg.pd_en;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);

   // a one-shot realign that no host write in the same cycle overrides
   sequence seq_oneshot_fire;
      fire && s_reg.sync_ctrl.next_only && !wr_sync;
   endsequence

   // divider enable bit as the auto-clear leaves it
   sequence seq_disarmed;
      !s_reg.sync_ctrl.div_en;
   endsequence

   // pin rise leaving the first flop, both sync enables standing one cycle later
   sequence seq_sync_rise;
      s_reg.sync_sh[0] && !s_reg.sync_sh[1] ##1 s_reg.sync_ctrl.master && s_reg.sync_ctrl.div_en;
   endsequence

   // reset values reach the outputs one edge after reset is seen; reset must not mask this one
   chk_reset_outputs: assert property (disable iff (1'b0) !rstn
      |=> !div_sync_pulse && data_output_enable && !low_rate_backup_oscillator
      && !low_rate_flag && sdio_pulldown_en && (reg_rdata == 8'h00))
      else $error("outputs not at reset values");

   // sync gating and the continuous realign
   chk_master_gate: assert property (!s_reg.sync_ctrl.master |=> !div_sync_pulse)
      else $error("divider sync pulse without master enable");
   chk_div_gate: assert property (!s_reg.sync_ctrl.div_en |=> !div_sync_pulse)
      else $error("divider sync pulse without divider enable");
   chk_continuous_sync: assert property ((sync_edge && s_reg.sync_ctrl.master && s_reg.sync_ctrl.div_en
      && !s_reg.sync_ctrl.next_only && !wr_sync) |=> div_sync_pulse && s_reg.sync_ctrl.div_en)
      else $error("continuous mode missed a realign");
   chk_sync_latency: assert property (seq_sync_rise |=> div_sync_pulse)
      else $error("synchronised sync edge did not realign");
   chk_no_stray_pulse: assert property (!sync_edge |=> !div_sync_pulse)
      else $error("divider sync pulse without a sync edge");
   chk_single_pulse: assert property (div_sync_pulse |=> !div_sync_pulse)
      else $error("sync pulse longer than one cycle");

   // one-shot realign, auto-clear and its readback
   chk_oneshot_fire: assert property (seq_oneshot_fire |=> div_sync_pulse ##1 !div_sync_pulse)
      else $error("one-shot realign wrong");
   chk_oneshot_clear: assert property (seq_oneshot_fire |=> seq_disarmed)
      else $error("divider enable not cleared after one-shot");
   chk_readback_clear: assert property (seq_oneshot_fire ##1 (reg_addr == dsoc_pkg::SYNC_CTRL_ADDR)
      |=> !reg_rdata[dsoc_pkg::SYNC_DIV_EN_BIT])
      else $error("cleared divider enable still reads one");

   // output enable pin
   chk_oe_pin_ignored: assert property (!s_reg.opts.oe_pin_en [*2] |-> data_output_enable)
      else $error("output enable pin not ignored");
   chk_oe_pin_active: assert property ((s_reg.opts.oe_pin_en && s_reg.oe_sh[1]) |=> !data_output_enable)
      else $error("output enable pin not obeyed");
   chk_oe_pin_released: assert property ((s_reg.opts.oe_pin_en && !s_reg.oe_sh[1]) |=> data_output_enable)
      else $error("outputs not enabled by the pin");
   chk_oe_pin_latency: assert property (!s_reg.oe_sh[0] |-> ##2 data_output_enable)
      else $error("low output enable pin did not reach the outputs");

   // low-rate detector and backup oscillator
   chk_detect_osc: assert property ((s_reg.opts.det_en && low_rate) |=> low_rate_backup_oscillator)
      else $error("low rate did not start oscillator");
   chk_detect_off: assert property ((!s_reg.opts.det_en && !s_reg.opts.run_osc) [*3]
      |-> !low_rate_backup_oscillator && !low_rate)
      else $error("disabled detector drives oscillator");
   chk_flag_disabled: assert property (!s_reg.opts.det_en |=> !low_rate_flag)
      else $error("low rate flag set with detector off");
   chk_run_osc: assert property (s_reg.opts.run_osc |=> low_rate_backup_oscillator)
      else $error("run-oscillator bit ignored");
   chk_osc_idle: assert property ((!s_reg.opts.run_osc && !(s_reg.opts.det_en && low_rate))
      |=> !low_rate_backup_oscillator)
      else $error("backup oscillator on without cause");

   // serial data pull-down and reserved read bits
   chk_pulldown: assert property (s_reg.opts.pd_dis |=> !sdio_pulldown_en)
      else $error("pull-down not removed");
   chk_pd_connected: assert property (!s_reg.opts.pd_dis |=> sdio_pulldown_en)
      else $error("pull-down removed while its disable bit is clear");
   chk_sync_rsvd_zero: assert property ((reg_addr == dsoc_pkg::SYNC_CTRL_ADDR) |=> (reg_rdata[7:3] == 5'h00))
      else $error("reserved sync control bits read nonzero");
   chk_opts_rsvd_zero: assert property ((reg_addr == dsoc_pkg::PIN_OPTS_ADDR) |=> (reg_rdata[6:4] == 3'h0)
      && !reg_rdata[1])
      else $error("reserved option bits read nonzero");
endmodule

// file: src/dsoc_pkg.sv
// Function
// - no sync function acts unless the master sync enable bit is one
// - divider sync enable gates the sync pulse to the divider
// - both enables set, next-only clear: realign on every sync pulse
// - both enables set, next-only set: realign on first pulse, ignore later ones
// - after a one-shot realign, hardware clears the divider sync enable bit
// - output enable pin acts only while its enable bit is one
// - detector enabled flags encode rates below about 5 MSPS
// - a detected low rate switches on the backup oscillator
// - detector disabled never turns on the backup oscillator
// - run-oscillator bit forces the backup oscillator on
// - pull-down disable bit removes the serial data pin pull-down
package dsoc_pkg;
   // register map
   localparam logic [12:0] SYNC_CTRL_ADDR = 13'h100;
   localparam logic [12:0] PIN_OPTS_ADDR = 13'h101;
   localparam logic [7:0] SYNC_CTRL_RESET = 8'h01;
   localparam logic [7:0] PIN_OPTS_RESET = 8'h88;
   // field positions, divider_sync_control
   localparam int SYNC_MASTER_BIT = 0;
   localparam int SYNC_DIV_EN_BIT = 1;
   localparam int SYNC_NEXT_ONLY_BIT = 2;
   // field positions, pin_and_oscillator_options
   localparam int OPT_PD_DIS_BIT = 0;
   localparam int OPT_RUN_OSC_BIT = 2;
   localparam int OPT_DET_EN_BIT = 3;
   localparam int OPT_OE_PIN_EN_BIT = 7;
   // low-rate detector timing
   localparam int LOW_RATE_MSPS = 5;
   localparam int REF_PERIOD_NS = 1000;
   localparam int MIN_EDGES_PER_REF = REF_PERIOD_NS * LOW_RATE_MSPS / 1000;

   typedef struct packed
   {
      logic next_only;
      logic div_en;
      logic master;
   } dsoc_sync_ctrl_t;

   typedef struct packed
   {
      logic oe_pin_en;
      logic det_en;
      logic run_osc;
      logic pd_dis;
   } dsoc_pin_opts_t;
endpackage

// file: src/dsoc_rate_detect.sv
`timescale 1ns/10ps
module dsoc_rate_detect #(
   parameter int MIN_EDGES = dsoc_pkg::MIN_EDGES_PER_REF,
   parameter int CNT_W = 8
)(
   input wire logic clk,
   input wire logic rstn,
   input wire logic enable,
   input wire logic ref_pin,
   output logic low_rate
);
   typedef struct packed
   {
      logic [2:0] ref_sh;
      logic [CNT_W-1:0] cnt;
      logic low;
   } dsoc_det_state_t;

   localparam logic [CNT_W-1:0] MIN_CNT = CNT_W'(MIN_EDGES);

   dsoc_det_state_t s_reg;
   dsoc_det_state_t s_next;

   ////////////////////////////////////////////////////////////////////////////
   // count encode-clock edges per reference period; few edges means slow clock
   always_comb
   begin
      s_next = s_reg;
      s_next.ref_sh = {s_reg.ref_sh[1:0], ref_pin};
      if (s_reg.cnt != {CNT_W{1'b1}})
      begin
         s_next.cnt = s_reg.cnt + 1'b1; // saturates, a fast clock must not wrap
      end
      if (s_reg.ref_sh[1] && !s_reg.ref_sh[2])
      begin
         s_next.cnt = '0;
         s_next.low = enable && (s_reg.cnt < MIN_CNT);
      end
      if (!enable)
      begin
         s_next.low = 1'b0;
      end
   end

   // a stopped clock also freezes this count; a limitation of a same-clock monitor
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         s_reg <= '0;
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   assign low_rate = s_reg.low;
endmodule

// file: test/dsoc_host_model.sv
`timescale 1ns/10ps
////////////////////////////////////////////////////////////
// host side of the decoded register port
module dsoc_host_model (
   input wire logic clk,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic [12:0] reg_addr,
   output logic [7:0] reg_wdata
);
   initial
   begin
      reg_wr = 1'b0;
      reg_addr = 13'h0000;
      reg_wdata = 8'h00;
   end
   // one-cycle strobe launched at the falling edge
   task automatic wr(input logic [12:0] a, input logic [7:0] d);
      @(negedge clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(negedge clk);
      reg_wr = 1'b0; // port quiet between accesses
      reg_wdata = ~d; // stale data inverted so nothing leans on it
   endtask
   // no read strobe: data follows the address one cycle late
   task automatic rd(input logic [12:0] a, output logic [7:0] d);
      @(negedge clk);
      reg_addr = a;
      repeat (2) @(negedge clk);
      d = reg_rdata;
   endtask
endmodule

// file: test/test_dsoc_ctrl.sv
`timescale 1ns/10ps
`define CHK(n, e, g) \
   begin samples_checked++; if ((g) !== (e)) begin fails++; \
   $display("ERROR %s expected %h seen %h", n, e, g); end end
////////////////////////////////////////////////////////////
module test_dsoc_ctrl;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic sync_pin = 1'b0;
   logic output_enable_pin_active_low = 1'b0; // pin low: outputs enabled while its bit is set
   logic rate_ref_pin = 1'b0;
   logic reg_wr, div_sync_pulse, data_output_enable, low_rate_backup_oscillator;
   logic low_rate_flag, sdio_pulldown_en;
   logic [12:0] reg_addr;
   logic [7:0] reg_wdata, reg_rdata, rd_v, d, got_v, exp_v;
   logic [7:0] notes[$];
   string got_n;
   event got_ev;
   int fails = 0;
   int samples_checked = 0;
   int pulses = 0;
   int ref_half = 8;
   dsoc_ctrl dsoc_ctrl_i (.clk, .rstn, .reg_wr, .reg_addr, .reg_wdata, .reg_rdata, .sync_pin,
      .output_enable_pin_active_low, .rate_ref_pin, .div_sync_pulse, .data_output_enable,
      .low_rate_backup_oscillator, .low_rate_flag, .sdio_pulldown_en);
   dsoc_host_model dsoc_host_model_i (.clk, .reg_rdata, .reg_wr, .reg_addr, .reg_wdata);
   initial
   begin
      forever #2 clk = ~clk;
   end
   // slow free-running reference; half period in clock cycles
   always
   begin
      repeat (ref_half) @(negedge clk);
      rate_ref_pin = ~rate_ref_pin;
   end
   always @(posedge clk)
      if (div_sync_pulse === 1'b1)
         pulses <= pulses + 1;
   // checker side: oldest note against the result just seen
   // pop once only: the macro names its expected value twice
   always @(got_ev)
   begin
      exp_v = notes.pop_front();
      `CHK(got_n, exp_v, got_v)
   end
   task automatic note(input string n, input logic [7:0] e, input logic [7:0] g);
      notes.push_back(e);
      got_n = n;
      got_v = g;
      ->got_ev;
      #1;
   endtask
   task automatic rd_note(input logic [12:0] a, input logic [7:0] e);
      dsoc_host_model_i.rd(a, rd_v);
      note("reg_rdata", e, rd_v);
   endtask
   task automatic sync_case(input logic [7:0] ctrl, input int n, input int e);
      int p0;
      dsoc_host_model_i.wr(13'h100, ctrl);
      p0 = pulses;
      repeat (n)
      begin
         @(negedge clk) sync_pin = 1'b1;
         repeat (3) @(negedge clk);
         sync_pin = 1'b0;
         repeat (8) @(negedge clk);
      end
      note("sync pulses", 8'(e), 8'(pulses - p0));
   endtask
   task automatic outs(input logic [7:0] e);
      repeat (6) @(negedge clk);
      note("outputs", e, {4'h0, low_rate_flag, low_rate_backup_oscillator, data_output_enable, sdio_pulldown_en});
   endtask
   task stop_test;
      $display("checks %0d errors %0d", samples_checked, fails);
      if (fails == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // watchdog sized well beyond the few hundred cycles of the tests
   initial
   begin
      #60000;
      fails++;
      stop_test();
   end
   initial
   begin
      void'($urandom(9));
      repeat (4) @(negedge clk);
      rstn = 1'b1;
      rd_note(13'h100, 8'h01);
      rd_note(13'h101, 8'h88);
      rd_note(13'h000, 8'h00);
      outs(8'h03);
      dsoc_host_model_i.wr(13'h100, 8'hFF);
      rd_note(13'h100, 8'h07);
      sync_case(8'h06, 1, 0);
      sync_case(8'h05, 1, 0);
      sync_case(8'h03, 2, 2);
      sync_case(8'h07, 2, 1);
      rd_note(13'h100, 8'h05);
      sync_case(8'h07, 1, 1);
      // output enable pin honoured only while its bit is set
      dsoc_host_model_i.wr(13'h101, 8'h80);
      output_enable_pin_active_low = 1'b0;
      outs(8'h03);
      output_enable_pin_active_low = 1'b1;
      outs(8'h01);
      dsoc_host_model_i.wr(13'h101, 8'h00);
      outs(8'h03);
      // fast reference looks like a low encode rate
      ref_half = 2;
      dsoc_host_model_i.wr(13'h101, 8'h08);
      repeat (40) @(negedge clk);
      outs(8'h0F);
      dsoc_host_model_i.wr(13'h101, 8'h00);
      outs(8'h03);
      dsoc_host_model_i.wr(13'h101, 8'h04);
      outs(8'h07);
      ref_half = 8;
      dsoc_host_model_i.wr(13'h101, 8'h08);
      repeat (60) @(negedge clk);
      outs(8'h03);
      repeat (4)
      begin
         d = 8'($urandom);
         dsoc_host_model_i.wr(13'h101, d);
         rd_note(13'h101, d & 8'h8D);
         outs({5'h00, d[2], ~d[7], ~d[0]});
      end
      stop_test();
   end
endmodule
